// file: bench/rhit_host_model.sv
// i2c host model driving the tag serial pins
`timescale 1ns/1ps
`default_nettype none
module rhit_host_model (
  input  wire logic dev_oe_i,
  input  wire logic dev_d_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic low_q;
  // data wire with pull-up, released reads high
  assign sda_o = !(low_q || (dev_oe_i && !dev_d_i));
  initial begin
    scl_o = 1'b1;
    low_q = 1'b0;
  end
  // one bit: set in low phase, sampled in high phase
  task automatic bit_io(input logic b, output logic r);
    #50 low_q = !b;
    #50 scl_o = 1'b1;
    #50 r = sda_o;
    #50 scl_o = 1'b0;
  endtask
  // data falls while clock high
  task automatic start();
    low_q = 1'b1;
    #100 scl_o = 1'b0;
  endtask
  // data rises while clock high, clock then stands
  task automatic stop();
    #50 low_q = 1'b1;
    #50 scl_o = 1'b1;
    #100 low_q = 1'b0;
    #100;
  endtask
  // eight bits then the ack slot
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(last, ack);
  endtask
endmodule
`default_nettype wire

// file: bench/test_rhit_tunnel_ctrl.sv
// testbench of the tag host-link interrupt and tunnel controller
`timescale 1ns/1ps
`default_nettype none
module test_rhit_tunnel_ctrl;
  logic        clk, rst_n, scl, sda, oe, sd, irq_n, ev_fd, ev_rf, t_cmd, busy, stop_o, dv, done, ok, tmo;
  logic [2:0]  sel = 3'b101;
  logic [1:0]  t_mode = 2'b10;
  logic [15:0] t_addr = 16'h0a5c;
  logic [7:0]  inq = 8'hff, t_len = 8'h10, rlim = 8'hff, dat, got, rb [4];
  int          error_cnt, n_tests, cyc, n_dv, n_dn, t0;
  logic [15:0] rows [3] = '{16'h7070, 16'h1010, 16'h4040};
  rhit_host_model host (.dev_oe_i(oe), .dev_d_i(sd), .scl_o(scl), .sda_o(sda));
  rhit_tunnel_ctrl #(.TICK_CYC(4)) DUT (
    .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .scl_i(scl), .sda_i(sda), .sda_o(sd), .sda_oe_o(oe),
    .irq_out_n_o(irq_n), .irq_select_field_i(sel), .rf_resp_evt_i(ev_rf), .rf_nvwrite_evt_i(1'b0),
    .field_evt_i(ev_fd), .field_present_i(1'b0), .bcc_error_i(1'b0), .rf_busy_i(busy), .tunnel_cmd_i(t_cmd),
    .tunnel_addr_i(t_addr), .tunnel_len_i(t_len), .tunnel_mode_i(t_mode), .inquiry_wait_limit_i(inq),
    .result_wait_limit_i(rlim), .rf_stop_o(stop_o), .tunnel_data_o(dat), .tunnel_data_valid_o(dv),
    .tunnel_done_o(done), .tunnel_ok_o(ok), .tunnel_timeout_o(tmo));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  // cycle ceiling and result byte capture
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dv === 1'b1) begin
      n_dv <= n_dv + 1;
      got <= dat;
    end
    if (done === 1'b1) n_dn <= n_dn + 1;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 400 && irq_n !== 1'b0; i++) begin
      @(posedge clk);
      #2;
    end
    chk({7'h0, irq_n}, 8'h00);
  endtask
  // address write, command bytes, stop, wait for answer
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n);
    logic [7:0] b [3];
    logic [7:0] r;
    logic       a;
    b = '{8'ha0, c, d};
    @(posedge clk);
    #2;
    host.start();
    for (int i = 0; i <= n; i++) begin
      host.xfer(b[i], 1'b1, r, a);
      chk({7'h0, a}, 8'h00);
    end
    host.stop();
    wait_irq();
  endtask
  // address read, n bytes, nack on last
  task automatic rd(input int n);
    logic a;
    @(posedge clk);
    #2;
    host.start();
    host.xfer(8'ha1, 1'b1, rb[0], a);
    chk({7'h0, a}, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
    for (int i = 0; i < n; i++) host.xfer(8'hff, i == n - 1, rb[i], a);
    host.stop();
  endtask
  task automatic ev(input logic [2:0] v);
    @(posedge clk) #2 {t_cmd, ev_rf, ev_fd} = v;
    @(posedge clk) #2 {t_cmd, ev_rf, ev_fd} = 3'b000;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // main sequence
  initial begin
    {rst_n, t_cmd, ev_rf, ev_fd, busy} = 5'h00;
    repeat (10) @(posedge clk);
    #2 rst_n = 1'b1;
    chk({7'h0, irq_n}, 8'h01);
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      wr(rhit_pkg::CMD_CTRL_WRITE, rows[k][15:8], 2);
      rd(1);
      chk(rb[0], 8'h00);
      chk({7'h0, stop_o}, {7'h0, rows[k][12]});
      wr(rhit_pkg::CMD_CTRL_READ, 8'h00, 1);
      rd(2);
      chk(rb[1] & 8'h7f, rows[k][7:0]);
    end
    $display("test rows done");
    ev(3'b001);
    wait_irq();
    busy = 1'b1;
    rd(1);
    chk(rb[0], 8'h07);
    busy = 1'b0;
    ev(3'b010);
    repeat (20) @(posedge clk);
    chk({7'h0, irq_n}, 8'h01);
    wr(rhit_pkg::CMD_CTRL_WRITE, 8'h00, 2);
    rd(1);
    ev(3'b010);
    wait_irq();
    rd(1);
    $display("test interrupts done");
    ev(3'b100);
    wait_irq();
    wr(rhit_pkg::CMD_INQUIRY, 8'h00, 1);
    rd(4);
    chk(rb[0], 8'h00);
    chk(rb[1], 8'h6a);
    chk(rb[2], 8'h5c);
    chk(rb[3], 8'h10);
    wr(rhit_pkg::CMD_RESULT_OK, 8'h3c, 2);
    chk(n_dv[7:0], 8'h00);
    rd(1);
    repeat (4) @(posedge clk);
    chk(got, 8'h3c);
    chk({5'h0, n_dn[0], ok, n_dv[0]}, 8'h07);
    $display("test tunnel done");
    inq = 8'h05;
    ev(3'b100);
    t0 = cyc;
    for (int i = 0; i < 200 && tmo !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    chk({7'h0, ((cyc - t0) inside {[20:23]})}, 8'h01);
    chk({7'h0, irq_n}, 8'h01);
    wr(rhit_pkg::CMD_INQUIRY, 8'h00, 1);
    rd(1);
    chk(rb[0], 8'h01);
    $display("test timeout done");
    // reset in mid-run with a tunnel pending
    ev(3'b100);
    @(posedge clk) #2 rst_n = 1'b0;
    @(posedge clk) #2 rst_n = 1'b1;
    chk({5'h0, irq_n, stop_o, ok}, 8'h04);
    wr(rhit_pkg::CMD_INQUIRY, 8'h00, 1);
    rd(1);
    chk(rb[0], 8'h01);
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// file: src/rhit_pin_sync.sv
// pin synchroniser and bus condition detector for the serial clock and data pins
`timescale 1ns/1ps
`default_nettype none
module rhit_pin_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } rhit_sync_state_type;

  rhit_sync_state_type q;
  rhit_sync_state_type d;

  // three stages: two for sync, third only for edge finding
  always_comb begin
    d    = q;
    d.s1 = {scl_i, sda_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // edges and start/stop seen only on stages two and three
  assign sda_o      = q.s2[0];
  assign scl_rise_o = q.s2[1] & ~q.s3[1];
  assign scl_fall_o = ~q.s2[1] & q.s3[1];
  assign start_o    = q.s2[1] & q.s3[1] & q.s3[0] & ~q.s2[0];
  assign stop_o     = q.s2[1] & q.s3[1] & ~q.s3[0] & q.s2[0];
endmodule
`default_nettype wire

// file: src/rhit_pkg.sv
// constants and state types for the tag host-link interrupt and tunnel controller
package rhit_pkg;

  // host command codes
  localparam logic [7:0] CMD_CTRL_READ  = 8'h68;
  localparam logic [7:0] CMD_CTRL_WRITE = 8'h78;
  localparam logic [7:0] CMD_INQUIRY    = 8'h28;
  localparam logic [7:0] CMD_RESULT_OK  = 8'hf8;
  localparam logic [7:0] CMD_RESULT_ERR = 8'he8;

  // command-result nibble codes of the status byte
  localparam logic [3:0] ST_NORMAL   = 4'h0;
  localparam logic [3:0] ST_ERROR    = 4'h1;
  localparam logic [3:0] ST_BUSY     = 4'h7;
  localparam logic [3:0] ST_SELFDIAG = 4'hb;

  // control-write data bit positions
  localparam int WR_MASK_RF_BIT = 6;
  localparam int WR_MASK_FD_BIT = 5;
  localparam int WR_RF_STOP_BIT = 4;

  // interrupt-select field bit positions
  localparam int SEL_FD_EN_BIT  = 0;
  localparam int SEL_RF_SRC_BIT = 1;
  localparam int SEL_RF_EN_BIT  = 2;

  // tunnel flag in upper start-address byte, bits 7:6
  localparam logic [1:0] ADDR_TUNNEL_FLAG = 2'b01;

  // reset values
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h50;
  localparam int         RX_DEPTH_RST   = 16;

  // wait-limit tick: limits count in units of this time
  localparam int CLK_FREQ_HZ  = 40_000_000;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES  = (CLK_FREQ_HZ / 1_000_000) * TICK_TIME_US;

  // serial engine states, gray along the usual path
  typedef enum logic [2:0] {
    B_IDLE     = 3'b000,
    B_ADDR     = 3'b001,
    B_ADDR_ACK = 3'b011,
    B_RX       = 3'b010,
    B_RX_ACK   = 3'b110,
    B_TX       = 3'b111,
    B_TX_ACK   = 3'b101,
    B_IGNORE   = 3'b100
  } rhit_bus_state_type;

  // tunnel transaction states
  typedef enum logic [1:0] {
    T_IDLE     = 2'b00,
    T_WAIT_INQ = 2'b01,
    T_WAIT_RES = 2'b11,
    T_SEND     = 2'b10
  } rhit_tun_state_type;

endpackage

// file: src/rhit_tunnel_ctrl.sv
// serial slave, interrupt request and tunnel handshake controller of the tag
`timescale 1ns/1ps
`default_nettype none
module rhit_tunnel_ctrl #(
  parameter logic [6:0] SLAVE_ADDR = rhit_pkg::SLAVE_ADDR_RST,
  parameter int         RX_DEPTH   = rhit_pkg::RX_DEPTH_RST,
  parameter int         TICK_CYC   = rhit_pkg::TICK_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             irq_out_n_o,
  input  wire logic [2:0]  irq_select_field_i,
  input  wire logic        rf_resp_evt_i,
  input  wire logic        rf_nvwrite_evt_i,
  input  wire logic        field_evt_i,
  input  wire logic        field_present_i,
  input  wire logic        bcc_error_i,
  input  wire logic        rf_busy_i,
  input  wire logic        tunnel_cmd_i,
  input  wire logic [15:0] tunnel_addr_i,
  input  wire logic [7:0]  tunnel_len_i,
  input  wire logic [1:0]  tunnel_mode_i,
  input  wire logic [7:0]  inquiry_wait_limit_i,
  input  wire logic [7:0]  result_wait_limit_i,
  output logic             rf_stop_o,
  output logic [7:0]       tunnel_data_o,
  output logic             tunnel_data_valid_o,
  output logic             tunnel_done_o,
  output logic             tunnel_ok_o,
  output logic             tunnel_timeout_o
);
  localparam int NW = $clog2(RX_DEPTH + 1);

  typedef struct packed {
    rhit_pkg::rhit_bus_state_type bus;
    logic [7:0]                   sh;
    logic [2:0]                   cnt;
    logic                         got;
    logic                         rw;
    logic                         sess;
    logic                         more;
    logic                         sda_oe;
    logic                         irq_n;
    logic [NW-1:0]                rx_n;
    logic [RX_DEPTH-1:0][7:0]     rxb;
    logic [3:0][7:0]              resp;
    logic [2:0]                   resp_len;
    logic [2:0]                   resp_idx;
    logic                         resp_pend;
    logic [7:0]                   cmd;
    logic [3:0]                   last_res;
    logic                         after_ctrl;
    logic                         host_busy;
    logic                         mask_rf;
    logic                         mask_fd;
    logic                         rf_stop;
    rhit_pkg::rhit_tun_state_type tun;
    logic [15:0]                  taddr;
    logic [7:0]                   tlen;
    logic [1:0]                   tmode;
    logic                         res_ok;
    logic [NW-1:0]                send_idx;
    logic [NW-1:0]                send_n;
    logic [7:0]                   tdata;
    logic                         tvalid;
    logic                         tdone;
    logic                         tok;
    logic                         ttimeout;
    logic                         t_restart;
  } rhit_ctrl_state_type;

  rhit_ctrl_state_type q;
  rhit_ctrl_state_type d;

  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       expired;
  logic       exec_c;
  logic       match_c;
  logic       rd_done_c;
  logic       set_rf;
  logic       set_fd;
  logic       set_tun;
  logic       set_any;
  logic       waiting;
  logic [7:0] txb;
  logic [7:0] ctrl_byte;
  logic [3:0] stat;

  rhit_pin_sync u_sync (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_s),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_c),
    .stop_o     (stop_c)
  );

  // wait timer runs only in a tunnel wait, paused during host commands
  assign waiting = (q.tun == rhit_pkg::T_WAIT_INQ) || (q.tun == rhit_pkg::T_WAIT_RES);

  rhit_wait_timer #(
    .TICK_CYC (TICK_CYC),
    .LIMIT_W  (8)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .restart_i (q.t_restart),
    .run_i     (waiting),
    .pause_i   (q.host_busy),
    .limit_i   ((q.tun == rhit_pkg::T_WAIT_INQ) ? inquiry_wait_limit_i : result_wait_limit_i),
    .expired_o (expired)
  );

  // interrupt sources
  assign set_rf  = irq_select_field_i[rhit_pkg::SEL_RF_EN_BIT] & ~q.mask_rf &
                   (irq_select_field_i[rhit_pkg::SEL_RF_SRC_BIT] ? rf_nvwrite_evt_i : rf_resp_evt_i);
  assign set_fd  = irq_select_field_i[rhit_pkg::SEL_FD_EN_BIT] & ~q.mask_fd & field_evt_i;
  assign set_tun = tunnel_cmd_i & (q.tun == rhit_pkg::T_IDLE);
  assign set_any = exec_c | set_rf | set_fd | set_tun;

  // byte on the data line: pending response or a status poll byte
  assign stat = (q.after_ctrl && rf_busy_i) ? rhit_pkg::ST_BUSY : q.last_res;
  assign txb  = q.resp_pend ? q.resp[q.resp_idx] : {4'h0, stat};
  assign ctrl_byte = {1'b0, q.mask_rf, q.mask_fd, q.rf_stop,
                      field_present_i & irq_select_field_i[rhit_pkg::SEL_FD_EN_BIT], 2'b00, bcc_error_i};

  // serial engine, command execution, interrupt and tunnel sequencing
  always_comb begin
    d          = q;
    exec_c     = 1'b0;
    match_c    = 1'b0;
    rd_done_c  = 1'b0;
    d.tvalid   = 1'b0;
    d.tdone    = 1'b0;
    d.ttimeout = 1'b0;
    d.t_restart = 1'b0;
    // engine always listens, also while the request is low
    case (q.bus)
      rhit_pkg::B_ADDR: begin
        if (scl_rise) begin
          d.sh  = {q.sh[6:0], sda_s};
          d.cnt = q.cnt + 3'd1;
          d.got = (q.cnt == 3'd7);
        end else if (scl_fall && q.got) begin
          d.got = 1'b0;
          if (q.sh[7:1] == SLAVE_ADDR) begin
            match_c     = 1'b1;
            d.bus       = rhit_pkg::B_ADDR_ACK;
            d.sda_oe    = 1'b1;
            d.rw        = q.sh[0];
            d.sess      = 1'b1;
            d.host_busy = 1'b1;
            d.rx_n      = '0;
            d.resp_idx  = '0;
          end else begin
            d.bus = rhit_pkg::B_IGNORE;
          end
        end
      end
      rhit_pkg::B_ADDR_ACK: begin
        if (scl_fall) begin
          d.cnt = 3'd0;
          if (q.rw) begin
            d.bus    = rhit_pkg::B_TX;
            d.sh     = txb;
            d.sda_oe = ~txb[7];
          end else begin
            d.bus    = rhit_pkg::B_RX;
            d.sda_oe = 1'b0;
          end
        end
      end
      rhit_pkg::B_RX: begin
        if (scl_rise) begin
          d.sh  = {q.sh[6:0], sda_s};
          d.cnt = q.cnt + 3'd1;
          d.got = (q.cnt == 3'd7);
        end else if (scl_fall && q.got) begin
          d.got = 1'b0;
          if (q.rx_n < NW'(RX_DEPTH)) begin
            d.rxb[q.rx_n] = q.sh;
            d.rx_n        = q.rx_n + NW'(1);
          end
          d.sda_oe = 1'b1;
          d.bus    = rhit_pkg::B_RX_ACK;
        end
      end
      rhit_pkg::B_RX_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.bus    = rhit_pkg::B_RX;
        end
      end
      rhit_pkg::B_TX: begin
        if (scl_fall) begin
          if (q.cnt == 3'd7) begin
            d.sda_oe = 1'b0;
            d.bus    = rhit_pkg::B_TX_ACK;
          end else begin
            d.sda_oe = ~q.sh[6];
            d.sh     = {q.sh[6:0], 1'b0};
            d.cnt    = q.cnt + 3'd1;
          end
        end
      end
      rhit_pkg::B_TX_ACK: begin
        // host ack continues, nack ends the read
        if (scl_rise) begin
          if (sda_s) begin
            d.bus = rhit_pkg::B_IGNORE;
          end else begin
            d.more = 1'b1;
            if (q.resp_pend && (q.resp_idx != (q.resp_len - 3'd1))) begin
              d.resp_idx = q.resp_idx + 3'd1;
            end
          end
        end else if (scl_fall && q.more) begin
          d.more   = 1'b0;
          d.bus    = rhit_pkg::B_TX;
          d.cnt    = 3'd0;
          d.sh     = txb;
          d.sda_oe = ~txb[7];
        end
      end
      rhit_pkg::B_IDLE, rhit_pkg::B_IGNORE: begin
        d.bus = q.bus;
      end
      default: begin
        d.bus = rhit_pkg::B_IDLE;
      end
    endcase
    // a start or stop closes the running session
    if ((start_c || stop_c) && q.sess) begin
      d.sess = 1'b0;
      if (q.rw) begin
        rd_done_c = 1'b1;
      end else if (q.rx_n != '0) begin
        exec_c = 1'b1;
      end else begin
        d.host_busy = 1'b0;
      end
    end
    if (start_c) begin
      d.bus    = rhit_pkg::B_ADDR;
      d.cnt    = 3'd0;
      d.got    = 1'b0;
      d.more   = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.bus    = rhit_pkg::B_IDLE;
      d.sda_oe = 1'b0;
    end
    // command execution once the write has stopped
    if (exec_c) begin
      d.resp_pend  = 1'b1;
      d.resp_idx   = '0;
      d.resp_len   = 3'd1;
      d.cmd        = q.rxb[0];
      d.after_ctrl = 1'b0;
      d.resp[0]    = {4'h0, rhit_pkg::ST_NORMAL};
      d.last_res   = rhit_pkg::ST_NORMAL;
      case (q.rxb[0])
        rhit_pkg::CMD_CTRL_READ: begin
          d.resp[1]  = ctrl_byte;
          d.resp_len = 3'd2;
        end
        rhit_pkg::CMD_CTRL_WRITE: begin
          if (q.rx_n >= NW'(2)) begin
            d.mask_rf = q.rxb[1][rhit_pkg::WR_MASK_RF_BIT];
            d.mask_fd = q.rxb[1][rhit_pkg::WR_MASK_FD_BIT];
            d.rf_stop = q.rxb[1][rhit_pkg::WR_RF_STOP_BIT];
          end else begin
            d.last_res = rhit_pkg::ST_ERROR;
          end
        end
        rhit_pkg::CMD_INQUIRY: begin
          if (waiting) begin
            d.resp[1]  = {rhit_pkg::ADDR_TUNNEL_FLAG, q.tmode, q.taddr[11:8]};
            d.resp[2]  = q.taddr[7:0];
            d.resp[3]  = q.tlen;
            d.resp_len = 3'd4;
          end else begin
            d.last_res = rhit_pkg::ST_ERROR;
          end
        end
        rhit_pkg::CMD_RESULT_OK, rhit_pkg::CMD_RESULT_ERR: begin
          if (q.tun == rhit_pkg::T_WAIT_RES) begin
            d.res_ok = (q.rxb[0] == rhit_pkg::CMD_RESULT_OK);
            d.send_n = q.rx_n;
          end else begin
            d.last_res = rhit_pkg::ST_ERROR;
          end
        end
        default: begin
          d.last_res = rhit_pkg::ST_ERROR;
        end
      endcase
      d.resp[0] = {4'h0, d.last_res};
    end
    // read session closed: follow-up actions
    if (rd_done_c) begin
      d.host_busy = 1'b0;
      if (q.resp_pend) begin
        d.resp_pend  = 1'b0;
        d.after_ctrl = (q.cmd == rhit_pkg::CMD_CTRL_READ);
        if ((q.cmd == rhit_pkg::CMD_INQUIRY) && (q.tun == rhit_pkg::T_WAIT_INQ)) begin
          d.tun       = rhit_pkg::T_WAIT_RES;
          d.t_restart = 1'b1;
        end else if (((q.cmd == rhit_pkg::CMD_RESULT_OK) || (q.cmd == rhit_pkg::CMD_RESULT_ERR)) &&
                     (q.tun == rhit_pkg::T_WAIT_RES) && (q.last_res == rhit_pkg::ST_NORMAL)) begin
          d.tun      = rhit_pkg::T_SEND;
          d.send_idx = NW'(1);
        end
      end else begin
        d.after_ctrl = 1'b0;
      end
    end
    // tunnel command from the reader
    if (set_tun) begin
      d.tun       = rhit_pkg::T_WAIT_INQ;
      d.taddr     = tunnel_addr_i;
      d.tlen      = tunnel_len_i;
      d.tmode     = tunnel_mode_i;
      d.t_restart = 1'b1;
    end
    // result data to the reader, after the host reply
    if (q.tun == rhit_pkg::T_SEND) begin
      if (q.send_idx < q.send_n) begin
        d.tdata    = q.rxb[q.send_idx];
        d.tvalid   = 1'b1;
        d.send_idx = q.send_idx + NW'(1);
      end else begin
        d.tdone = 1'b1;
        d.tok   = q.res_ok;
        d.tun   = rhit_pkg::T_IDLE;
      end
    end
    // request line: sets win over clears
    // sources named directly: set_any is built from exec_c of this process
    if (exec_c || set_rf || set_fd || set_tun) begin
      d.irq_n = 1'b0;
    end else if ((match_c && q.sh[0]) || (expired && waiting)) begin
      d.irq_n = 1'b1;
    end
    // wait limit reached: abandon the tunnel transaction
    if (expired && waiting) begin
      d.tun      = rhit_pkg::T_IDLE;
      d.ttimeout = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q          <= '0;
      q.irq_n    <= 1'b1;
      q.resp_len <= 3'd1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign sda_o               = 1'b0 & q.sda_oe; // open drain: only ever pulls low
  assign sda_oe_o            = q.sda_oe;
  assign irq_out_n_o         = q.irq_n;
  assign rf_stop_o           = q.rf_stop;
  assign tunnel_data_o       = q.tdata;
  assign tunnel_data_valid_o = q.tvalid;
  assign tunnel_done_o       = q.tdone;
  assign tunnel_ok_o         = q.tok;
  assign tunnel_timeout_o    = q.ttimeout;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_SERIAL_IRQ: assert property (ce_i && exec_c |=> !irq_out_n_o)
    else $error("finished command did not pull request low");
  AST_READ_RELEASE: assert property (ce_i && match_c && q.sh[0] && !set_any |=> irq_out_n_o)
    else $error("read address match did not release request");
  AST_FD_IRQ: assert property (ce_i && field_evt_i && irq_select_field_i[0] && !q.mask_fd |=> !irq_out_n_o)
    else $error("field interrupt not raised");
  AST_FD_MASK: assert property (ce_i && irq_out_n_o && field_evt_i && q.mask_fd && !exec_c && !set_rf && !set_tun
                                |=> irq_out_n_o)
    else $error("masked field interrupt reached request line");
  AST_RF_IRQ: assert property (ce_i && rf_resp_evt_i && irq_select_field_i[2] && !irq_select_field_i[1] &&
                               !q.mask_rf |=> !irq_out_n_o)
    else $error("rf interrupt not raised");
  AST_TUN_IRQ: assert property (ce_i && set_tun |=> !irq_out_n_o && q.tun == rhit_pkg::T_WAIT_INQ)
    else $error("tunnel command did not raise request");
  AST_INQ_ADDR: assert property (ce_i && exec_c && q.rxb[0] == rhit_pkg::CMD_INQUIRY && waiting
                                 |=> q.resp[1][7:6] == 2'b01 && q.resp[1][5:4] == q.tmode)
    else $error("inquiry address flag or mode wrong");
  AST_BUSY_POLL: assert property (ce_i && q.bus == rhit_pkg::B_ADDR_ACK && scl_fall && q.rw && !q.resp_pend &&
                                  q.after_ctrl && rf_busy_i |=> q.sh[3:0] == rhit_pkg::ST_BUSY)
    else $error("poll after control read not busy");
  AST_ADDR_ACK: assert property (ce_i && match_c |=> sda_oe_o && q.bus == rhit_pkg::B_ADDR_ACK)
    else $error("matched address not acknowledged");
  AST_TIMEOUT_IDLE: assert property (tunnel_timeout_o |-> q.tun == rhit_pkg::T_IDLE)
    else $error("tunnel not idle after timeout");
  AST_RES_AFTER_RESP: assert property (tunnel_data_valid_o |-> !q.resp_pend)
    else $error("reader data before host reply");

  COV_TIMEOUT: cover property (tunnel_timeout_o);
  COV_TUN_DONE: cover property (tunnel_done_o && tunnel_ok_o);
  COV_READ_MATCH: cover property (match_c && q.sh[0] && !irq_out_n_o);
  COV_CTRL_WRITE: cover property (exec_c && q.rxb[0] == rhit_pkg::CMD_CTRL_WRITE);
endmodule
`default_nettype wire

// file: src/rhit_wait_timer.sv
// pausable wait-limit timer counting ticks of a prescaler
`timescale 1ns/1ps
`default_nettype none
module rhit_wait_timer #(
  parameter int TICK_CYC = rhit_pkg::TICK_CYCLES,
  parameter int LIMIT_W  = 8
) (
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               ce_i,
  input  wire logic               restart_i,
  input  wire logic               run_i,
  input  wire logic               pause_i,
  input  wire logic [LIMIT_W-1:0] limit_i,
  output logic                    expired_o
);
  localparam int PW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic [PW-1:0]      pre;
    logic [LIMIT_W-1:0] ticks;
    logic               fired;
    logic               expired;
  } rhit_timer_state_type;

  rhit_timer_state_type q;
  rhit_timer_state_type d;

  // prescaler and tick count, frozen while paused
  always_comb begin
    d         = q;
    d.expired = 1'b0;
    if (restart_i) begin
      d = '0;
    end else if (run_i && !pause_i && !q.fired) begin
      if (q.pre == PW'(TICK_CYC - 1)) begin
        d.pre   = '0;
        d.ticks = q.ticks + LIMIT_W'(1);
        if ((q.ticks + LIMIT_W'(1)) >= limit_i) begin
          d.fired   = 1'b1;
          d.expired = 1'b1;
        end
      end else begin
        d.pre = q.pre + PW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign expired_o = q.expired;
endmodule
`default_nettype wire
